// ==== pkg/vip_pkg.sv ====
// Constants, register map and carrier types of the vectored interrupt prioritizer
`default_nettype none
package vip_pkg;
	// Source and vector counts
	localparam int NUM_VEC = 16;
	localparam int NUM_PA = 8;
	localparam int NUM_PC = 4;
	localparam int NUM_GPIO = NUM_PA + NUM_PC;
	localparam int NUM_GRP = 3;

	// Fixed ranking, vector 0 ranks highest
	localparam int VEC_WDT = 0;
	localparam int VEC_TMR1 = 1;
	localparam int VEC_TMR0 = 2;
	localparam int VEC_ADC = 3;
	localparam int VEC_PA_TOP = 11;
	localparam int VEC_PA6 = 5;
	localparam int VEC_PC_TOP = 15;

	// Register offsets in the control register space
	localparam logic [11:0] ADDR_REQ_PERIPH = 12'hFC0;
	localparam logic [11:0] ADDR_PRI_HI_PERIPH = 12'hFC1;
	localparam logic [11:0] ADDR_PRI_LO_PERIPH = 12'hFC2;
	localparam logic [11:0] ADDR_PORT_A_REQUEST_PENDING = 12'hFC3;
	localparam logic [11:0] ADDR_PRI_HI_PORT_A = 12'hFC4;
	localparam logic [11:0] ADDR_PRI_LO_PORT_A = 12'hFC5;
	localparam logic [11:0] ADDR_REQ_PORT_C = 12'hFC6;
	localparam logic [11:0] ADDR_PRI_HI_PORT_C = 12'hFC7;
	localparam logic [11:0] ADDR_PRI_LO_PORT_C = 12'hFC8;
	localparam logic [11:0] ADDR_EDGE_SELECT = 12'hFCD;
	localparam logic [11:0] ADDR_CONTROL = 12'hFCF;
	localparam logic [11:0] ADDR_EVENT_STATUS = 12'hFD0;
	localparam logic [11:0] ADDR_EVENT_MASK = 12'hFD1;

	// Field positions
	localparam int CTL_GLOBAL_EN_BIT = 7;
	localparam int CTL_WDT_INT_BIT = 0;
	localparam int EVT_TAKEN_BIT = 0;
	localparam int EVT_OVERRUN_BIT = 1;
	localparam int EVT_POLLED_BIT = 2;
	localparam int NUM_EVT = 3;

	// Reset values
	localparam logic [7:0] RST_REQUEST = 8'h00;
	localparam logic [7:0] RST_PRIORITY = 8'h00;
	localparam logic [7:0] RST_EDGE_SELECT = 8'h00;
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] RST_EVENT = 8'h00;

	// Priority level codes, {hi,lo}
	localparam logic [1:0] LVL_OFF = 2'h0;

	// Register bus request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [7:0] wdata;
	} vip_bus_type;

	// Request handed to the processor core
	typedef struct packed {
		logic valid;
		logic [3:0] vector;
		logic [15:0] vector_addr;
	} vip_core_req_type;
endpackage
`default_nettype wire

// ==== hdl/vip_prioritizer.sv ====
// Vectored interrupt prioritizer: pending bits, edge detection, arbitration, registers
// How it works
// [RL1] Seventeen sources (twelve port pins, five peripherals) land on sixteen vectors.
// [RL2] The comparator and port A pin six set the same pending bit and share a vector.
// [RL3] Port A pins trigger on a selectable rising or falling edge, port C pins on both edges.
// [RL4] Every source has a two-bit priority giving three levels, plus off.
// [RL5] The watchdog raises a request only when it is set to interrupt instead of reset.
// [RL6] Equal levels are settled by fixed ranking, lowest vector number first.
// [RL7] Vector words sit high byte at the even address, low byte at the next odd one.
// [RL8] A source request sets its pending bit whether handling is vectored or polled.
// [RL9] With global enable set, the winning pending request is forwarded to the core.
// [RL10] With global enable clear, nothing is forwarded and pending bits stay readable.
// [RL11] The core suspends, runs the service routine and resumes after taking a vector.
// [RL12] Parameters remove the converter source and the port C sources on small variants.
// [RL13] The port A pending register is eight bits at FC3, reset zero, pins seven to zero.
// [RL14] A pending bit reads one while its request waits and zero otherwise.
// [RL15] A pending bit clears on vector acknowledge or a written one; a new request wins.
// [RL16] Pins are synchronised and each qualifying edge is a single-cycle request.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module vip_prioritizer
	import vip_pkg::*;
#(
	parameter bit HAS_ADC = 1'b1,
	parameter bit HAS_PORT_C = 1'b1,
	parameter logic [15:0] VECTOR_BASE = 16'h0008
)
(
	// Clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// Register port
	input wire vip_bus_type BUS,
	output logic [7:0] RDATA,
	// Port pins
	input wire logic [NUM_PA-1:0] PA_PIN,
	input wire logic [NUM_PC-1:0] PC_PIN,
	// Peripheral request pulses
	input wire logic WDT_EVT,
	input wire logic TMR0_EVT,
	input wire logic TMR1_EVT,
	input wire logic ADC_EVT,
	input wire logic CMP_EVT,
	// Processor core handshake
	output vip_core_req_type CORE_REQ,
	input wire logic CORE_ACK,
	// Event interrupt
	output logic IRQ
);

	// Elaboration checks
	if (VECTOR_BASE[0] != 1'b0)
	begin : g_chk_base
		$error("VECTOR_BASE must be even");
	end

	logic [2:0][NUM_GPIO-1:0] sync;
	logic [NUM_GPIO-1:0] gpio_evt;
	logic [NUM_VEC-1:0] pend;
	logic [NUM_VEC-1:0] src_set;
	logic [NUM_VEC-1:0] sw_clr;
	logic [NUM_VEC-1:0] ack_clr;
	logic [NUM_VEC-1:0] pri_hi;
	logic [NUM_VEC-1:0] pri_lo;
	logic [NUM_VEC-1:0] present;
	logic [NUM_PA-1:0] edge_rise;
	logic [7:0] control;
	logic [NUM_EVT-1:0] evt_status;
	logic [NUM_EVT-1:0] evt_mask;
	logic [NUM_EVT-1:0] evt_set;
	logic found;
	logic [3:0] best;
	logic [1:0] best_lvl;
	logic gie;
	logic ack_take;
	logic [7:0] next_rdata;

	// Register group and bit of a vector
	function automatic int grp_of(input int v);
		int g;
		g = 0;
		if (v > VEC_PA_TOP)
			g = 2;
		else if (v > VEC_ADC)
			g = 1;
		return g;
	endfunction

	function automatic int bit_of(input int v);
		int b;
		b = VEC_ADC - v;
		if (v > VEC_PA_TOP)
			b = VEC_PC_TOP - v;
		else if (v > VEC_ADC)
			b = VEC_PA_TOP - v;
		return b;
	endfunction

	// Collect one register byte out of a per-vector set of bits
	function automatic logic [7:0] grp_byte(input logic [NUM_VEC-1:0] v, input int g);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < NUM_VEC; i++)
		begin
			if (grp_of(i) == g)
				r[bit_of(i)] = v[i];
		end
		return r;
	endfunction

	function automatic logic [11:0] req_addr(input int g);
		logic [11:0] a;
		a = ADDR_REQ_PERIPH;
		if (g == 1)
			a = ADDR_PORT_A_REQUEST_PENDING;
		else if (g == 2)
			a = ADDR_REQ_PORT_C;
		return a;
	endfunction

	function automatic logic [11:0] hi_addr(input int g);
		logic [11:0] a;
		a = ADDR_PRI_HI_PERIPH;
		if (g == 1)
			a = ADDR_PRI_HI_PORT_A;
		else if (g == 2)
			a = ADDR_PRI_HI_PORT_C;
		return a;
	endfunction

	function automatic logic [11:0] lo_addr(input int g);
		logic [11:0] a;
		a = ADDR_PRI_LO_PERIPH;
		if (g == 1)
			a = ADDR_PRI_LO_PORT_A;
		else if (g == 2)
			a = ADDR_PRI_LO_PORT_C;
		return a;
	endfunction

	assign gie = control[CTL_GLOBAL_EN_BIT];
	// Only a request still on the output may be acknowledged
	assign ack_take = CORE_ACK & CORE_REQ.valid;

	// Pin synchroniser; stage 0 feeds stage 1 only, stage 2 is the edge history
	// Reset loads live levels, so a pin idling high shows no false edge at release
	always_ff @(posedge CLK)
	begin
		if (!NRST)
			sync <= {3{PC_PIN, PA_PIN}};
		else
		begin
			sync[0] <= {PC_PIN, PA_PIN};
			sync[1] <= sync[0];
			sync[2] <= sync[1];
		end
	end

	// One-cycle edge pulses per pin
	for (genvar p = 0; p < NUM_GPIO; p++)
	begin : g_edge
		logic rise;
		logic fall;
		assign rise = sync[1][p] & ~sync[2][p]; // [RL16]
		assign fall = ~sync[1][p] & sync[2][p]; // [RL16]
		if (p < NUM_PA)
		begin : g_sel
			assign gpio_evt[p] = edge_rise[p] ? rise : fall; // [RL3]
		end
		else
		begin : g_dual
			assign gpio_evt[p] = rise | fall; // [RL3]
		end
	end

	// Per-vector request, presence and clear terms
	for (genvar v = 0; v < NUM_VEC; v++)
	begin : g_vec
		if (v == VEC_WDT)
		begin : g_wdt
			assign src_set[v] = WDT_EVT & control[CTL_WDT_INT_BIT]; // [RL5]
			assign present[v] = 1'b1;
		end
		else if (v == VEC_TMR1)
		begin : g_t1
			assign src_set[v] = TMR1_EVT;
			assign present[v] = 1'b1;
		end
		else if (v == VEC_TMR0)
		begin : g_t0
			assign src_set[v] = TMR0_EVT;
			assign present[v] = 1'b1;
		end
		else if (v == VEC_ADC)
		begin : g_adc
			assign src_set[v] = ADC_EVT & HAS_ADC; // [RL12]
			assign present[v] = HAS_ADC; // [RL12]
		end
		else if (v == VEC_PA6)
		begin : g_pa6
			assign src_set[v] = gpio_evt[VEC_PA_TOP - v] | CMP_EVT; // [RL2]
			assign present[v] = 1'b1;
		end
		else if (v <= VEC_PA_TOP)
		begin : g_pa
			assign src_set[v] = gpio_evt[VEC_PA_TOP - v]; // [RL1]
			assign present[v] = 1'b1;
		end
		else
		begin : g_pc
			assign src_set[v] = gpio_evt[NUM_PA + VEC_PC_TOP - v] & HAS_PORT_C; // [RL12]
			assign present[v] = HAS_PORT_C; // [RL12]
		end
		// Writing one to a pending bit clears it
		assign sw_clr[v] = BUS.wr & (BUS.addr == req_addr(grp_of(v)))
			& BUS.wdata[bit_of(v)]; // [RL15]
		assign ack_clr[v] = ack_take & (CORE_REQ.vector == 4'(v)); // [RL15]
	end

	// Pending bits; a new request beats any clear in the same cycle
	always_ff @(posedge CLK)
	begin
		if (!NRST)
			pend <= '0; // [RL13]
		else
		begin
			for (int i = 0; i < NUM_VEC; i++)
			begin
				if (src_set[i])
					pend[i] <= 1'b1; // [RL8] [RL15]
				else if (sw_clr[i] | ack_clr[i])
					pend[i] <= 1'b0; // [RL14] [RL15]
			end
		end
	end

	// Priority, edge select and control registers
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			pri_hi <= {2{RST_PRIORITY}};
			pri_lo <= {2{RST_PRIORITY}};
			edge_rise <= RST_EDGE_SELECT;
			control <= RST_CONTROL;
			evt_mask <= RST_EVENT[NUM_EVT-1:0];
		end
		else if (BUS.wr)
		begin
			for (int i = 0; i < NUM_VEC; i++)
			begin
				if (BUS.addr == hi_addr(grp_of(i)))
					pri_hi[i] <= BUS.wdata[bit_of(i)] & present[i]; // [RL4]
				if (BUS.addr == lo_addr(grp_of(i)))
					pri_lo[i] <= BUS.wdata[bit_of(i)] & present[i]; // [RL4]
			end
			if (BUS.addr == ADDR_EDGE_SELECT)
				edge_rise <= BUS.wdata; // [RL3]
			if (BUS.addr == ADDR_CONTROL)
				control <= BUS.wdata;
			if (BUS.addr == ADDR_EVENT_MASK)
				evt_mask <= BUS.wdata[NUM_EVT-1:0];
		end
	end

	// Highest level wins; the strict compare lets the lowest vector keep a tie
	always_comb
	begin
		logic [1:0] lvl;
		lvl = LVL_OFF;
		found = 1'b0;
		best = 4'h0;
		best_lvl = LVL_OFF;
		for (int i = 0; i < NUM_VEC; i++)
		begin
			lvl = {pri_hi[i], pri_lo[i]}; // [RL4]
			if (pend[i] && lvl > best_lvl) // [RL6]
			begin
				found = 1'b1;
				best = 4'(i);
				best_lvl = lvl;
			end
		end
	end

	// Core request; dropped in the acknowledge cycle so a stale vector is never offered
	always_ff @(posedge CLK)
	begin
		if (!NRST)
			CORE_REQ <= '0;
		else
		begin
			CORE_REQ.valid <= gie & found & ~ack_take; // [RL9] [RL10]
			CORE_REQ.vector <= best;
			CORE_REQ.vector_addr <= VECTOR_BASE + {11'h000, best, 1'b0}; // [RL7]
		end
	end

	// Block events that feed the interrupt line
	assign evt_set[EVT_TAKEN_BIT] = ack_take; // [RL11]
	assign evt_set[EVT_OVERRUN_BIT] = |(src_set & pend);
	assign evt_set[EVT_POLLED_BIT] = ~gie & |(src_set & present); // [RL10]

	// Sticky status cleared by reading it; an event in the read cycle survives
	always_ff @(posedge CLK)
	begin
		if (!NRST)
			evt_status <= RST_EVENT[NUM_EVT-1:0];
		else if (BUS.rd && BUS.addr == ADDR_EVENT_STATUS)
			evt_status <= evt_set;
		else
			evt_status <= evt_status | evt_set;
	end

	// Level interrupt from unmasked status, one flop behind the status
	always_ff @(posedge CLK)
	begin
		if (!NRST)
			IRQ <= 1'b0;
		else
			IRQ <= |(evt_status & evt_mask);
	end

	// Read mux; unmapped offsets read zero
	always_comb
	begin
		next_rdata = 8'h00;
		for (int g = 0; g < NUM_GRP; g++)
		begin
			if (BUS.addr == req_addr(g))
				next_rdata = grp_byte(pend, g); // [RL13] [RL14]
			if (BUS.addr == hi_addr(g))
				next_rdata = grp_byte(pri_hi, g);
			if (BUS.addr == lo_addr(g))
				next_rdata = grp_byte(pri_lo, g);
		end
		case (BUS.addr)
			ADDR_EDGE_SELECT: next_rdata = edge_rise;
			ADDR_CONTROL: next_rdata = control;
			ADDR_EVENT_STATUS: next_rdata = {5'h00, evt_status};
			ADDR_EVENT_MASK: next_rdata = {5'h00, evt_mask};
			default: next_rdata = next_rdata;
		endcase
	end

	// Read data stand only in the cycle after the read strobe
	always_ff @(posedge CLK)
	begin
		if (!NRST)
			RDATA <= 8'h00;
		else if (BUS.rd)
			RDATA <= next_rdata;
		else
			RDATA <= 8'h00;
	end

endmodule
`default_nettype wire

// ==== tb/vip_prioritizer_monitor.sv ====
// Port checker for the interrupt prioritizer, bound into the design
`timescale 1ns/1ps
`default_nettype none
module vip_prioritizer_monitor
	import vip_pkg::*;
#(
	parameter logic [15:0] VECTOR_BASE = 16'h0008
)
(
	// Clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// Register port
	input wire vip_bus_type BUS,
	input wire logic [7:0] RDATA,
	// Core side and event line
	input wire vip_core_req_type CORE_REQ,
	input wire logic CORE_ACK,
	input wire logic IRQ
);
	logic gen;
	logic [2:0] msk;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);

	// Shadow of global enable and event mask, tracked from bus writes
	always_ff @(posedge CLK)
	begin
		if (!NRST)
		begin
			gen <= 1'h0;
			msk <= 3'h0;
		end
		else if (BUS.wr && BUS.addr == ADDR_CONTROL)
			gen <= BUS.wdata[7];
		else if (BUS.wr && BUS.addr == ADDR_EVENT_MASK)
			msk <= BUS.wdata[2:0];
	end

	a_reset_quiet:
	assert property (!$past(NRST) |-> !CORE_REQ.valid && !IRQ && RDATA == 8'h00)
	else $error("outputs not quiet after reset");
	a_rdata_idle:
	assert property (!$past(BUS.rd) |-> RDATA == 8'h00)
	else $error("read data outside its cycle");
	a_hole_reads_zero:
	assert property ($past(BUS.rd) && $past(BUS.addr) == 12'h123 |-> RDATA == 8'h00)
	else $error("unmapped address read nonzero");
	a_vector_word:
	assert property (CORE_REQ.valid |->
		CORE_REQ.vector_addr == VECTOR_BASE + {11'h000, CORE_REQ.vector, 1'h0})
	else $error("vector address not even word");
	a_ack_drops:
	assert property (CORE_REQ.valid && CORE_ACK |=> !CORE_REQ.valid)
	else $error("offer kept after acknowledge");
	a_polled_silent:
	assert property (!gen && !$past(gen) |-> !CORE_REQ.valid)
	else $error("request forwarded while disabled");
	a_mask_quiet:
	assert property ($past(msk) == 3'h0 |-> !IRQ)
	else $error("interrupt with all events masked");
	a_taken_irq:
	assert property (CORE_REQ.valid && CORE_ACK && msk[0] |-> ##2 IRQ)
	else $error("taken event did not interrupt");
endmodule

bind vip_prioritizer vip_prioritizer_monitor #(.VECTOR_BASE(VECTOR_BASE)) u_mon (
	.CLK(CLK), .NRST(NRST), .BUS(BUS), .RDATA(RDATA),
	.CORE_REQ(CORE_REQ), .CORE_ACK(CORE_ACK), .IRQ(IRQ)
);
`default_nettype wire

// ==== tb/vip_core_model.sv ====
// Processor core stand-in that takes offered vectors after a set wait
`timescale 1ns/1ps
`default_nettype none
module vip_core_model
	import vip_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Offer and wait length
	input wire vip_core_req_type req,
	input wire logic [3:0] lat,
	output logic ack,
	// Record of taken vectors
	output logic [3:0] taken,
	output logic [7:0] n_taken
);
	logic [3:0] cnt;

	// One ack per offer; the wait restarts only once valid has fallen
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			ack <= 1'h0;
			cnt <= 4'h0;
			taken <= 4'h0;
			n_taken <= 8'h00;
		end
		else if (ack)
		begin
			ack <= 1'h0; // Suspend, serve, resume
			taken <= req.vector; // Word fetched from this vector
			n_taken <= n_taken + 8'h01;
		end
		else if (!req.valid)
			cnt <= 4'h0;
		else if (cnt >= lat)
			ack <= 1'h1;
		else
			cnt <= cnt + 4'h1;
	end
endmodule
`default_nettype wire

// ==== tb/vip_prioritizer_tb.sv ====
// Self-checking bench for the interrupt prioritizer
`timescale 1ns/1ps
`default_nettype none
module vip_prioritizer_tb
	import vip_pkg::*;
;
	logic clk = 1'h0;
	logic nrst = 1'h0;
	vip_bus_type bus = '0;
	logic [7:0] pa = 8'h00;
	logic [3:0] pc = 4'h0;
	logic [4:0] ev = 5'h00;
	logic [3:0] lat = 4'h0;
	logic [7:0] rdata;
	vip_core_req_type core_req;
	logic core_ack;
	logic irq;
	logic [3:0] taken;
	logic [7:0] n_taken;
	logic [7:0] d;
	logic [7:0] dc;
	logic [7:0] es;
	logic [7:0] rdata_small;
	logic [7:0] npa;
	logic [3:0] npc;
	int n_errors = 0;
	int n_compared = 0;

	// 200 MHz system clock
	always #2.5 clk = ~clk;

	vip_prioritizer dut (
		.CLK(clk), .NRST(nrst), .BUS(bus), .RDATA(rdata), .PA_PIN(pa), .PC_PIN(pc),
		.WDT_EVT(ev[0]), .TMR0_EVT(ev[1]), .TMR1_EVT(ev[2]), .ADC_EVT(ev[3]),
		.CMP_EVT(ev[4]), .CORE_REQ(core_req), .CORE_ACK(core_ack), .IRQ(irq)
	);

	// Small variant without converter or port C sources
	vip_prioritizer #(.HAS_ADC(1'b0), .HAS_PORT_C(1'b0)) dut_small (
		.CLK(clk), .NRST(nrst), .BUS(bus), .RDATA(rdata_small), .PA_PIN(pa), .PC_PIN(pc),
		.WDT_EVT(ev[0]), .TMR0_EVT(ev[1]), .TMR1_EVT(ev[2]), .ADC_EVT(ev[3]),
		.CMP_EVT(ev[4]), .CORE_REQ(), .CORE_ACK(1'b0), .IRQ()
	);

	vip_core_model core (
		.clk(clk), .nrst(nrst), .req(core_req), .lat(lat), .ack(core_ack),
		.taken(taken), .n_taken(n_taken)
	);

	// Port A pending expected from a level change and the edge choice per pin
	function automatic logic [7:0] pin_exp(input logic [7:0] old_lvl,
		input logic [7:0] new_lvl, input logic [7:0] sel);
		return (old_lvl ^ new_lvl) & ~(new_lvl ^ sel);
	endfunction

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One bus write or idle cycle, with source pulses in the same cycle
	task automatic op(input logic w, input logic [11:0] a, input logic [7:0] v,
		input logic [4:0] e);
		@(posedge clk);
		bus <= '{wr: w, rd: 1'h0, addr: a, wdata: v};
		ev <= e;
		@(posedge clk);
		bus <= '0;
		ev <= 5'h00;
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		@(posedge clk);
		bus <= '{wr: 1'h0, rd: 1'h1, addr: a, wdata: 8'h00};
		@(posedge clk);
		bus <= '0;
		#1 chk(rdata, exp);
	endtask

	// Wait for the core to take one vector, with a random ack delay
	task automatic take(input logic [3:0] v);
		logic [7:0] n0;
		n0 = n_taken;
		lat <= 4'($urandom_range(0, 6));
		for (int k = 0; k < 60 && n_taken === n0; k++)
			@(posedge clk);
		#1 chk({4'h0, taken}, {4'h0, v});
		chk(n_taken, n0 + 8'h01);
	endtask

	task automatic test_done();
		$display("compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Main sequence: reset, polled, pins, vectored
	initial
	begin
		d = 8'($urandom(32'h6662));
		repeat (12) @(posedge clk);
		nrst <= 1'h1;
		rd(ADDR_PORT_A_REQUEST_PENDING, RST_REQUEST);
		rd(12'h123, 8'h00);
		op(1'h1, ADDR_EVENT_MASK, 8'h07, 5'h00);
		// Nonzero levels, so only the global enable keeps the core request low
		op(1'h1, ADDR_PRI_HI_PERIPH, 8'h0F, 5'h00);
		op(1'h0, 12'h000, 8'h00, 5'h0A);
		rd(ADDR_REQ_PERIPH, 8'h03);
		chk(rdata_small, 8'h02);
		chk({7'h00, core_req.valid}, 8'h00);
		chk({7'h00, irq}, 8'h01);
		rd(ADDR_EVENT_STATUS, 8'h04);
		rd(ADDR_EVENT_STATUS, 8'h00);
		// Clearing write meets a fresh request, which must survive
		op(1'h1, ADDR_REQ_PERIPH, 8'h03, 5'h02);
		rd(ADDR_REQ_PERIPH, 8'h02);
		rd(ADDR_EVENT_STATUS, 8'h06);
		op(1'h1, ADDR_REQ_PERIPH, 8'h02, 5'h10);
		rd(ADDR_PORT_A_REQUEST_PENDING, 8'h40);
		op(1'h1, ADDR_PORT_A_REQUEST_PENDING, 8'h40, 5'h00);
		rd(ADDR_PORT_A_REQUEST_PENDING, 8'h00);
		// Random pin moves against a random edge choice
		for (int i = 0; i < 12; i++)
		begin
			npa = 8'($urandom);
			npc = 4'($urandom);
			es = 8'($urandom);
			op(1'h1, ADDR_EDGE_SELECT, es, 5'h00);
			d = pin_exp(pa, npa, es);
			dc = {4'h0, pc ^ npc};
			pa <= npa;
			pc <= npc;
			repeat (6) @(posedge clk);
			rd(ADDR_PORT_A_REQUEST_PENDING, d);
			rd(ADDR_REQ_PORT_C, dc);
			chk(rdata_small, 8'h00);
			op(1'h1, ADDR_PORT_A_REQUEST_PENDING, 8'hFF, 5'h00);
			op(1'h1, ADDR_REQ_PORT_C, 8'h0F, 5'h00);
		end
		// Level beats rank; watchdog ignored outside interrupt mode
		op(1'h1, ADDR_PRI_HI_PERIPH, 8'h02, 5'h00);
		op(1'h1, ADDR_PRI_LO_PERIPH, 8'h06, 5'h00);
		op(1'h1, ADDR_EVENT_MASK, 8'h01, 5'h00);
		op(1'h1, ADDR_CONTROL, 8'h80, 5'h00);
		op(1'h0, 12'h000, 8'h00, 5'h07);
		take(4'(VEC_TMR0));
		take(4'(VEC_TMR1));
		rd(ADDR_REQ_PERIPH, 8'h00);
		// Equal levels fall back on rank; off level stays pending
		op(1'h1, ADDR_PRI_HI_PERIPH, 8'h0E, 5'h00);
		op(1'h1, ADDR_CONTROL, 8'h81, 5'h00);
		op(1'h0, 12'h000, 8'h00, 5'h0E);
		take(4'(VEC_TMR1));
		take(4'(VEC_TMR0));
		op(1'h0, 12'h000, 8'h00, 5'h01);
		take(4'(VEC_WDT));
		rd(ADDR_REQ_PERIPH, 8'h01);
		test_done();
	end

	// Hang guard, far past the expected run length
	initial
	begin
		repeat (20000) @(posedge clk);
		n_errors++;
		test_done();
	end
endmodule
`default_nettype wire
